//--- logic/sewc_dev.sv
// device end: 64 x 16 serial eeprom with write protection
// assumes: pins arrive asynchronously from the host through the link
//
// Summary of operation
// RULE1: all address write programs every word once
// RULE2: write disabled after reset
// RULE3: disable command restores the reset protection
// RULE4: disabled: writes ignored, reads still work
// RULE5: enabled: any complete write programs
// RULE6: host disables writes after finishing
// RULE7: frame is start, opcode, address, data
// RULE8: select low aborts a read anywhere
// RULE9: select low before last bit drops write
// RULE10: started program cycle always completes
// RULE11: select rising with clock high samples data
// RULE12: host keeps pins low in standby
// RULE13: select low discards input, returns idle
// RULE14: host drops select before power off
// RULE15: dummy zero driven on address_lsb edge
// RULE16: host drops select within four clocks
// RULE17: fifth clock after ready may start
// RULE18: leading zeros skipped before start bit
// RULE19: sample and drive on clock rise
// RULE20: status low busy, high ready; off unselected
// RULE21: enable holds until disable command
// RULE22: program time counted on system clock
`timescale 1ns/10ps
module sewc_dev
    import sewc_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = SEWC_PROG_CYC // program length
) (
    input wire logic mclk_i,      // system clock
    input wire logic reset_i,     // synchronous reset, active high
    sewc_link_if.dev link,        // serial pins
    output logic busy_o,          // program cycle running
    output logic wen_o            // writes enabled
);
    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    typedef enum logic [2:0] {
        SEWC_PH_IDLE,   // waiting for start bit
        SEWC_PH_CMD,    // opcode and address
        SEWC_PH_DATA,   // data word of a write
        SEWC_PH_READ,   // shifting out read data
        SEWC_PH_ARMED,  // write complete, waits for select low
        SEWC_PH_DONE    // ignore until select low
    } sewc_phase_t;

    typedef struct packed {
        logic [2:0] cs_s;        // select synchroniser
        logic [2:0] sk_s;        // clock synchroniser
        logic [2:0] di_s;        // data synchroniser
        logic cs_f;              // filtered select
        logic sk_f;              // filtered clock
        sewc_phase_t phase;      // frame phase
        logic [3:0] bitcnt;      // bits within phase
        logic [6:0] sr;          // opcode/address shifter
        logic [1:0] op;          // received opcode
        logic [5:0] addr;        // received address
        logic [15:0] word;       // data word in or out
        logic all;               // whole array target
        logic wen;               // write enable latch
        logic st_en;             // status shown after write
        logic [2:0] rdy_cnt;     // clocks seen since ready
        logic busy;              // program cycle running
        logic [31:0] cnt;        // program cycle counter
        logic dout;              // data out level
        logic doe;               // data out enable
        logic [SEWC_WORDS-1:0][SEWC_WBITS-1:0] mem; // array
    } sewc_dev_t;

    sewc_dev_t r;       // registered state
    sewc_dev_t next_r;  // next state

    logic cs_n;       // filtered select after this cycle
    logic sk_n;       // filtered clock after this cycle
    logic edge_s;     // sample edge for data in
    logic di_v;       // data in at the sample edge
    logic [7:0] full; // opcode and address at the last bit

    // ----------------------------------------------------------
    // next state
    // ----------------------------------------------------------
    always_comb begin
        next_r = r;
        // three stage synchronisers; for select and clock, second and third must agree
        next_r.cs_s = {r.cs_s[1:0], link.cs};
        next_r.sk_s = {r.sk_s[1:0], link.sk};
        next_r.di_s = {r.di_s[1:0], link.di};
        cs_n = (r.cs_s[1] == r.cs_s[2]) ? r.cs_s[2] : r.cs_f;
        sk_n = (r.sk_s[1] == r.sk_s[2]) ? r.sk_s[2] : r.sk_f;
        next_r.cs_f = cs_n;
        next_r.sk_f = sk_n;
        di_v = r.di_s[2];
        // clock rise, or select rising over a high clock
        edge_s = cs_n & ((sk_n & ~r.sk_f) | (~r.cs_f & sk_n)); // [RULE19] [RULE11]
        full = {r.sr, di_v};

        // program cycle timer, free of select and pins
        if (r.busy) begin // [RULE10] [RULE22]
            next_r.cnt = r.cnt - 32'h1;
            if (r.cnt == 32'h1) begin
                next_r.busy = 1'b0;
                if (r.all) begin // [RULE1]
                    for (int i = 0; i < SEWC_WORDS; i++) begin
                        next_r.mem[i] = r.word;
                    end
                end else begin
                    next_r.mem[r.addr] = r.word;
                end
            end
        end

        if (!cs_n) begin
            // select low: drop partial frame, release data out
            next_r.phase = SEWC_PH_IDLE; // [RULE13] [RULE8] [RULE9]
            next_r.bitcnt = 4'h0;
            next_r.doe = 1'b0; // [RULE20]
            next_r.rdy_cnt = 3'h0;
            // status ends once select drops after ready, so the next
            // select opens a fresh frame whose start bit is not skipped
            if (!r.busy) begin // [RULE20] [RULE17]
                next_r.st_en = 1'b0;
            end
            // only a fully received write starts on select fall
            if (r.cs_f && r.phase == SEWC_PH_ARMED && !r.busy) begin // [RULE5]
                next_r.busy = 1'b1;
                next_r.cnt = PROG_CYCLES;
                next_r.st_en = 1'b1;
            end
        end else begin
            case (r.phase)
                SEWC_PH_IDLE: begin
                    // status on data out after a write
                    next_r.doe = r.st_en; // [RULE20]
                    next_r.dout = ~r.busy;
                    if (edge_s && !r.busy) begin
                        if (!r.st_en || r.rdy_cnt == 3'(SEWC_READY_SKIP)) begin
                            // zeros before start are skipped
                            if (di_v) begin // [RULE18] [RULE17]
                                next_r.phase = SEWC_PH_CMD; // [RULE7]
                                next_r.bitcnt = 4'h0;
                                next_r.st_en = 1'b0;
                                next_r.doe = 1'b0;
                            end
                        end else begin
                            // first four clocks after ready ignored
                            next_r.rdy_cnt = r.rdy_cnt + 3'h1; // [RULE17]
                        end
                    end
                end
                SEWC_PH_CMD: begin
                    if (edge_s) begin
                        next_r.sr = full[6:0];
                        next_r.bitcnt = r.bitcnt + 4'h1;
                        if (r.bitcnt == 4'(SEWC_OBITS + SEWC_ABITS - 1)) begin // [RULE7]
                            next_r.op = full[7:6];
                            next_r.addr = full[5:0];
                            next_r.bitcnt = 4'h0;
                            next_r.all = 1'b0;
                            next_r.phase = SEWC_PH_DONE;
                            case (full[7:6])
                                SEWC_OP_READ: begin
                                    // dummy zero on the address_lsb edge
                                    next_r.dout = 1'b0; // [RULE15]
                                    next_r.doe = 1'b1;
                                    next_r.word = r.mem[full[5:0]];
                                    next_r.phase = SEWC_PH_READ; // [RULE4]
                                end
                                SEWC_OP_WRITE: begin
                                    if (r.wen) begin // [RULE4]
                                        next_r.phase = SEWC_PH_DATA;
                                    end
                                end
                                SEWC_OP_ERASE: begin
                                    if (r.wen) begin // [RULE4]
                                        next_r.word = SEWC_ERASED;
                                        next_r.phase = SEWC_PH_ARMED;
                                    end
                                end
                                default: begin
                                    case (full[5:4])
                                        SEWC_EX_EN: begin
                                            next_r.wen = 1'b1; // [RULE21]
                                        end
                                        SEWC_EX_DIS: begin
                                            next_r.wen = 1'b0; // [RULE3]
                                        end
                                        SEWC_EX_ALL: begin
                                            next_r.all = 1'b1;
                                            if (r.wen) begin // [RULE4]
                                                next_r.phase = SEWC_PH_DATA;
                                            end
                                        end
                                        default: begin
                                            next_r.all = 1'b1;
                                            next_r.word = SEWC_ERASED;
                                            if (r.wen) begin // [RULE4]
                                                next_r.phase = SEWC_PH_ARMED;
                                            end
                                        end
                                    endcase
                                end
                            endcase
                        end
                    end
                end
                SEWC_PH_DATA: begin
                    // sixteen data bits, msb first
                    if (edge_s) begin
                        next_r.word = {r.word[14:0], di_v};
                        next_r.bitcnt = r.bitcnt + 4'h1;
                        if (r.bitcnt == 4'(SEWC_WBITS - 1)) begin // [RULE9]
                            next_r.phase = SEWC_PH_ARMED;
                        end
                    end
                end
                SEWC_PH_READ: begin
                    // one bit per rise, then next address
                    if (edge_s) begin
                        next_r.dout = r.word[15]; // [RULE19]
                        next_r.bitcnt = r.bitcnt + 4'h1;
                        next_r.word = {r.word[14:0], 1'b0};
                        if (r.bitcnt == 4'(SEWC_WBITS - 1)) begin
                            next_r.addr = r.addr + 6'h1;
                            next_r.word = r.mem[r.addr + 6'h1];
                        end
                    end
                end
                default: begin
                    // armed or done: further clocks ignored
                end
            endcase
        end
    end

    // ----------------------------------------------------------
    // registers
    // ----------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            r <= '0;
            r.phase <= SEWC_PH_IDLE;
            r.wen <= 1'b0; // [RULE2]
            r.dout <= 1'b1;
            r.mem <= {SEWC_WORDS{SEWC_MEM_RST}};
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------
    // outputs
    // ----------------------------------------------------------
    assign link.dout = r.dout;
    assign link.doe = r.doe;
    assign busy_o = r.busy;
    assign wen_o = r.wen;
endmodule : sewc_dev

//--- logic/sewc_pkg.sv
// package: constants shared by both ends of the serial eeprom link
// assumes: one 10 MHz clock on both ends, pins joined by sewc_link_if
package sewc_pkg;
    // ----------------------------------------------------------
    // array geometry
    // ----------------------------------------------------------
    localparam int SEWC_WORDS = 64;  // words in the array
    localparam int SEWC_WBITS = 16;  // bits per word
    localparam int SEWC_ABITS = 6;   // address bits
    localparam int SEWC_OBITS = 2;   // operation code bits
    // ----------------------------------------------------------
    // operation codes and the extended codes in address[5:4]
    // ----------------------------------------------------------
    localparam logic [1:0] SEWC_OP_EXT = 2'h0;   // extended group
    localparam logic [1:0] SEWC_OP_WRITE = 2'h1; // single word write
    localparam logic [1:0] SEWC_OP_READ = 2'h2;  // read
    localparam logic [1:0] SEWC_OP_ERASE = 2'h3; // single word erase
    localparam logic [1:0] SEWC_EX_DIS = 2'h0;   // write_disable_cmd
    localparam logic [1:0] SEWC_EX_ALL = 2'h1;   // all_address_write
    localparam logic [1:0] SEWC_EX_ERAL = 2'h2;  // erase all
    localparam logic [1:0] SEWC_EX_EN = 2'h3;    // write enable
    localparam logic [15:0] SEWC_ERASED = 16'hFFFF; // erased word
    localparam logic [15:0] SEWC_MEM_RST = 16'hFFFF; // array at reset
    // ----------------------------------------------------------
    // timing
    // ----------------------------------------------------------
    localparam int SEWC_CLK_HZ = 10_000_000; // mclk_i rate
    localparam int SEWC_CLK_NS = 100;        // mclk_i period
    localparam int SEWC_PROG_MS = 10;        // program_cycle_time
    localparam int SEWC_PROG_CYC = SEWC_PROG_MS * (SEWC_CLK_HZ / 1000);
    localparam int SEWC_SK_HALF_NS = 500;    // serial clock half period
    localparam int SEWC_SK_HALF_CYC =
        (SEWC_SK_HALF_NS + SEWC_CLK_NS - 1) / SEWC_CLK_NS;
    localparam int SEWC_TCS_NS = 450;        // least select low time
    localparam int SEWC_TCS_CYC =
        (SEWC_TCS_NS + SEWC_CLK_NS - 1) / SEWC_CLK_NS;
    localparam int SEWC_TSV_NS = 500;        // select to status valid
    localparam int SEWC_TSV_CYC =
        (SEWC_TSV_NS + SEWC_CLK_NS - 1) / SEWC_CLK_NS;
    localparam int SEWC_SYNC_CYC = 3;        // pin synchroniser depth
    localparam int SEWC_READY_SKIP = 4;      // clocks ignored after ready
    // ----------------------------------------------------------
    // host user commands
    // ----------------------------------------------------------
    typedef enum logic [2:0] {
        SEWC_CMD_READ, SEWC_CMD_WRITE, SEWC_CMD_ERASE, SEWC_CMD_EN,
        SEWC_CMD_DIS, SEWC_CMD_ALL, SEWC_CMD_ERAL
    } sewc_cmd_t;
endpackage : sewc_pkg

//--- logic/sewc_link_if.sv
// interface: the four pins between host and device
// assumes: data out has a pull-up, so an undriven line reads high
`timescale 1ns/10ps
interface sewc_link_if;
    logic cs;    // chip select, host drives
    logic sk;    // serial_clock_in, host drives
    logic di;    // serial_data_in, host drives
    logic dout;  // data out level, device drives
    logic doe;   // data out enable, high while device drives
    logic line;  // resolved data out wire
    // pull-up when the device releases the line
    assign line = doe ? dout : 1'b1;
    modport host (output cs, output sk, output di, input line);
    modport dev (input cs, input sk, input di, output dout, output doe);
endinterface : sewc_link_if

//--- logic/sewc_host.sv
// host end: builds command frames and drives the serial pins
// assumes: the device sits on the far side of sewc_link_if
`timescale 1ns/10ps
module sewc_host
    import sewc_pkg::*;
(
    input wire logic mclk_i,          // system clock
    input wire logic reset_i,         // synchronous reset, active high
    sewc_link_if.host link,           // serial pins
    input wire logic cmd_valid_i,     // command request
    input sewc_cmd_t cmd_op_i,        // command kind
    input wire logic [5:0] cmd_addr_i, // word address
    input wire logic [15:0] cmd_data_i, // write data
    output logic cmd_ready_o,         // may take a command
    output logic rsp_valid_o,         // read data pulse
    output logic [15:0] rsp_data_o    // read data
);
    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    typedef enum logic [2:0] {
        SEWC_H_IDLE, SEWC_H_SHIFT, SEWC_H_GAP, SEWC_H_POLL
    } sewc_hstate_t;

    typedef struct packed {
        sewc_hstate_t st;     // sequencer state
        logic [3:0] div;      // half period divider
        logic [4:0] rises;    // clock rises in frame
        logic [4:0] nbits;    // rises wanted in frame
        logic [24:0] frame;   // outgoing bits, msb first
        logic rd;             // frame is a read
        logic poll;           // poll status after gap
        logic [2:0] do_s;     // data out synchroniser
        logic do_f;           // filtered data out
        logic cs;             // select pin
        logic sk;             // clock pin
        logic di;             // data pin
        logic ready;          // command ready
        logic rsp_v;          // response pulse
        logic [15:0] rsp;     // response shifter
    } sewc_host_t;

    sewc_host_t r;       // registered state
    sewc_host_t next_r;  // next state
    logic [1:0] op;      // opcode of the request
    logic [5:0] ad;      // address field of the request

    // ----------------------------------------------------------
    // next state
    // ----------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.rsp_v = 1'b0;
        next_r.do_s = {r.do_s[1:0], link.line};
        if (r.do_s[1] == r.do_s[2]) begin
            next_r.do_f = r.do_s[2];
        end
        op = SEWC_OP_EXT;
        ad = cmd_addr_i;
        case (cmd_op_i)
            SEWC_CMD_READ: op = SEWC_OP_READ;
            SEWC_CMD_WRITE: op = SEWC_OP_WRITE;
            SEWC_CMD_ERASE: op = SEWC_OP_ERASE;
            SEWC_CMD_EN: ad = {SEWC_EX_EN, 4'h0};
            SEWC_CMD_DIS: ad = {SEWC_EX_DIS, 4'h0};
            SEWC_CMD_ALL: ad = {SEWC_EX_ALL, 4'h0};
            default: ad = {SEWC_EX_ERAL, 4'h0};
        endcase
        case (r.st)
            SEWC_H_IDLE: begin
                // pins stay low while idle
                if (cmd_valid_i && r.ready) begin // [RULE12] [RULE14]
                    next_r.ready = 1'b0;
                    next_r.cs = 1'b1;
                    next_r.di = 1'b1; // start bit
                    next_r.frame = {op, ad, cmd_data_i, 1'b0}; // [RULE7]
                    next_r.rd = (cmd_op_i == SEWC_CMD_READ);
                    next_r.poll = (op != SEWC_OP_EXT) ||
                        (ad[5:4] == SEWC_EX_ALL) || (ad[5:4] == SEWC_EX_ERAL);
                    next_r.poll = next_r.poll && !next_r.rd;
                    next_r.nbits = 5'h09;
                    if (cmd_op_i == SEWC_CMD_READ) begin
                        next_r.nbits = 5'h1A;
                    end else if (cmd_op_i == SEWC_CMD_WRITE ||
                                 cmd_op_i == SEWC_CMD_ALL) begin
                        next_r.nbits = 5'h19;
                    end
                    next_r.rises = 5'h0;
                    next_r.div = 4'(SEWC_SK_HALF_CYC - 1);
                    next_r.st = SEWC_H_SHIFT;
                end
            end
            SEWC_H_SHIFT: begin
                next_r.div = r.div - 4'h1;
                if (r.div == 4'h0) begin
                    next_r.div = 4'(SEWC_SK_HALF_CYC - 1);
                    if (!r.sk) begin
                        // rise; sample bit driven on the previous rise
                        next_r.sk = 1'b1;
                        next_r.rises = r.rises + 5'h1;
                        if (r.rd && r.rises >= 5'h0A) begin
                            next_r.rsp = {r.rsp[14:0], r.do_f};
                        end
                    end else begin
                        next_r.sk = 1'b0;
                        if (r.rises == r.nbits) begin
                            next_r.cs = 1'b0;
                            next_r.di = 1'b0;
                            next_r.rsp_v = r.rd;
                            next_r.div = 4'(SEWC_TCS_CYC);
                            next_r.st = SEWC_H_GAP;
                        end else begin
                            next_r.di = r.frame[24];
                            next_r.frame = {r.frame[23:0], 1'b0};
                        end
                    end
                end
            end
            SEWC_H_GAP: begin
                // select low time, then poll or idle
                next_r.div = r.div - 4'h1;
                if (r.div == 4'h0) begin
                    if (r.poll) begin
                        next_r.cs = 1'b1;
                        next_r.div = 4'(SEWC_TSV_CYC + SEWC_SYNC_CYC);
                        next_r.st = SEWC_H_POLL;
                    end else begin
                        next_r.ready = 1'b1;
                        next_r.st = SEWC_H_IDLE;
                    end
                end
            end
            default: begin
                // no clocks while polling, drop select on ready
                if (r.div != 4'h0) begin
                    next_r.div = r.div - 4'h1;
                end else if (r.do_f) begin // [RULE16]
                    next_r.cs = 1'b0;
                    next_r.poll = 1'b0;
                    next_r.div = 4'(SEWC_TCS_CYC);
                    next_r.st = SEWC_H_GAP;
                end
            end
        endcase
    end

    // ----------------------------------------------------------
    // registers
    // ----------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            r <= '0;
            r.st <= SEWC_H_IDLE;
            r.ready <= 1'b1;
            r.do_s <= 3'h7;
            r.do_f <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------
    // outputs
    // ----------------------------------------------------------
    assign link.cs = r.cs;
    assign link.sk = r.sk;
    assign link.di = r.di;
    assign cmd_ready_o = r.ready;
    assign rsp_valid_o = r.rsp_v;
    assign rsp_data_o = r.rsp;
endmodule : sewc_host

//--- test/sewc_link_sva.sv
// checker: link pins, busy and enable flags of the device
// assumes: tb_top instantiates it beside the link, PROG_CYCLES is 50
`timescale 1ns/10ps
module sewc_link_sva (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic cs,
    input wire logic sk,
    input wire logic di,
    input wire logic dout,
    input wire logic doe,
    input wire logic busy_o,
    input wire logic wen_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    wen_at_reset_a: assert property ($fell(reset_i) |-> !wen_o)
        else $error("enable set after reset");
    prog_gate_a: assert property ($rose(busy_o) |-> $past(wen_o))
        else $error("program while writes disabled");
    prog_len_a: assert property ($rose(busy_o) |->
        (busy_o throughout ##49 1) ##1 !busy_o) else $error("busy length");
    busy_status_a: assert property (busy_o && doe |-> !dout)
        else $error("status not low while busy");
    wen_hold_a: assert property ($changed(wen_o) |-> !busy_o)
        else $error("enable changed during program");
    doe_sel_a: assert property ($rose(doe) |-> cs)
        else $error("output driven while unselected");
    doe_off_a: assert property (!cs [*8] |-> !doe)
        else $error("output not released");
    ready_drop_a: assert property ($fell(busy_o) && cs |->
        ##[1:30] !cs) else $error("select held after ready");
    idle_pins_a: assert property (!cs |-> !sk && !di)
        else $error("pins active in standby");
endmodule : sewc_link_sva

//--- test/tb_top.sv
// testbench: host and device joined by the link, random words
// assumes: design as declared, program length cut to 50 cycles
`timescale 1ns/10ps
module tb_top;
    import sewc_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic cmd_valid = 1'b0;
    sewc_cmd_t cmd_op = SEWC_CMD_READ;
    logic [5:0] cmd_addr = 6'h0;
    logic [15:0] cmd_data = 16'h0;
    logic cmd_ready, rsp_valid, busy, wen, rd = 1'b0;
    logic [15:0] rsp_data, got;
    logic [31:0] seed, r;
    int num_errors = 0, total_checks = 0, nr = 0, i;
    sewc_link_if lk();
    sewc_dev #(.PROG_CYCLES(50)) sewc_dev_inst (.mclk_i(mclk_i),
        .reset_i(reset_i), .link(lk.dev), .busy_o(busy), .wen_o(wen));
    sewc_host sewc_host_inst (.mclk_i(mclk_i), .reset_i(reset_i),
        .link(lk.host), .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op),
        .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
        .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid),
        .rsp_data_o(rsp_data));
    sewc_link_sva sewc_link_sva_inst (.mclk_i(mclk_i), .reset_i(reset_i),
        .cs(lk.cs), .sk(lk.sk), .di(lk.di), .dout(lk.dout), .doe(lk.doe),
        .busy_o(busy), .wen_o(wen));
    always #50 mclk_i = ~mclk_i;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input string n, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // one command through the host, waits for its end
    task automatic run(input sewc_cmd_t op, input logic [5:0] a,
        input logic [15:0] d);
        got = 16'hXXXX;
        @(posedge mclk_i);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        rd <= (op == SEWC_CMD_READ);
        @(posedge mclk_i);
        cmd_valid <= 1'b0;
        @(posedge mclk_i);
        for (int n = 0; n < 3000 && cmd_ready !== 1'b1; n++) begin
            @(posedge mclk_i);
            if (rsp_valid === 1'b1) got = rsp_data;
        end
        chk("ready", 16'h1, 16'(cmd_ready));
    endtask : run
    // dummy bit: the wire is low at the rise after address_lsb
    always @(posedge lk.sk or negedge lk.cs) begin
        if (!lk.cs) nr = 0;
        else begin
            nr++;
            if (rd && nr == 10) chk("dummy", 16'h0, 16'(lk.line));
        end
    end
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    initial begin
        #3_000_000;
        num_errors++;
        conclude();
    end
    initial begin
        seed = 32'h5F;
        repeat (8) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
        run(SEWC_CMD_READ, 6'h2A, 16'h0);
        chk("rd_rst", SEWC_MEM_RST, got);
        chk("wen_rst", 16'h0, 16'(wen));
        run(SEWC_CMD_WRITE, 6'h05, 16'h1234);
        run(SEWC_CMD_READ, 6'h05, 16'h0);
        chk("rd_lock", SEWC_MEM_RST, got);
        run(SEWC_CMD_EN, 6'h0, 16'h0);
        chk("wen_on", 16'h1, 16'(wen));
        for (i = 0; i < 3; i++) begin
            r = xs();
            run(SEWC_CMD_WRITE, r[5:0], r[31:16]);
            run(SEWC_CMD_READ, r[5:0], 16'h0);
            chk("rd_word", r[31:16], got);
        end
        r = xs();
        run(SEWC_CMD_ALL, 6'h0, r[15:0]);
        for (i = 0; i < 64; i += 63) begin
            run(SEWC_CMD_READ, i[5:0], 16'h0);
            chk("rd_all", r[15:0], got);
        end
        run(SEWC_CMD_ERASE, 6'h3F, 16'h0);
        run(SEWC_CMD_READ, 6'h3F, 16'h0);
        chk("rd_erase", SEWC_ERASED, got);
        run(SEWC_CMD_DIS, 6'h0, 16'h0);
        chk("wen_off", 16'h0, 16'(wen));
        run(SEWC_CMD_ALL, 6'h0, ~r[15:0]);
        run(SEWC_CMD_READ, 6'h11, 16'h0);
        chk("rd_kept", r[15:0], got);
        conclude();
    end
endmodule : tb_top
